// ===== pkg/epv_cfg.svh
// Purpose: constants of the program/verify mode controller
// Assumes: mclk at 250 MHz
// Notes:   times in ns, cycle counts derived from them
`ifndef EPV_CFG_SVH
`define EPV_CFG_SVH
`define EPV_CLK_NS          4
`define EPV_PULSE_LO_NS     100000
`define EPV_PULSE_HI_NS     10000
`define EPV_SETUP_NS        12000
`define EPV_ENTRY_NS        20000
`define EPV_PULSE_LO_CYC    (`EPV_PULSE_LO_NS / `EPV_CLK_NS)
`define EPV_PULSE_HI_CYC    ((`EPV_PULSE_HI_NS + `EPV_CLK_NS - 1) / `EPV_CLK_NS)
`define EPV_SETUP_CYC       ((`EPV_SETUP_NS + `EPV_CLK_NS - 1) / `EPV_CLK_NS)
`define EPV_ENTRY_CYC       ((`EPV_ENTRY_NS + `EPV_CLK_NS - 1) / `EPV_CLK_NS)
`define EPV_PULSE_COUNT     5'h19
`define EPV_OSC_HALF        5'h18
`define EPV_ENC_LAST        13'h001F
`define EPV_REG_CTRL        12'h000
`define EPV_REG_ADDR        12'h004
`define EPV_REG_WDATA       12'h008
`define EPV_REG_STATUS      12'h00C
`define EPV_REG_RDATA       12'h010
`define EPV_CTRL_GO         0
`define EPV_CTRL_OP_LSB     1
`endif

// ===== pkg/epv_pkg.sv
// Purpose: types of the program/verify mode controller
// Assumes: nothing
// Notes:   operations are issued through the control register
package epv_pkg;
    typedef enum logic [2:0] {
        OP_ENTER, OP_EXIT, OP_SIG, OP_VERIFY, OP_PGM_CODE, OP_PGM_ENC, OP_PGM_SEC1, OP_PGM_SEC2
    } epv_op_e;
    typedef enum logic [2:0] {
        PH_IDLE, PH_ENTRY, PH_SETUP, PH_LOW, PH_HIGH, PH_HOLD, PH_READ
    } epv_phase_e;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } epv_apb_req_s;
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } epv_apb_rsp_s;
    typedef struct packed {
        logic        devResetAct;
        logic        programStoreStrobeN;
        logic        latchOrProgramPulse;
        logic        externalAccessHigh;
        logic        progSupplyOn;
        logic        oscOut;
        logic [12:0] addr;
        logic        port2Bit7ModeSel;
        logic        port2Bit6ModeSel;
        logic        port3Bit7ModeSel;
        logic        port3Bit6ModeSel;
        logic [7:0]  port0Out;
        logic        port0OeN;
    } epv_pins_s;
endpackage

// ===== hdl/epv_programmer.sv
// Purpose: external programmer for the pin-driven program/verify mode of an 8-bit controller
// Assumes: software orders each operation over APB and polls the status register
// Notes:   one operation at a time; orders written while busy are ignored
`timescale 1ns/100ps
`include "epv_cfg.svh"

module epv_programmer #(
    parameter int PULSE_LO_CYC = `EPV_PULSE_LO_CYC,
    parameter int PULSE_HI_CYC = `EPV_PULSE_HI_CYC,
    parameter int SETUP_CYC    = `EPV_SETUP_CYC,
    parameter int ENTRY_CYC    = `EPV_ENTRY_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire epv_pkg::epv_apb_req_s apbReq,
    output epv_pkg::epv_apb_rsp_s     apbRsp,
    output epv_pkg::epv_pins_s        pins,
    input  wire logic [7:0]           port0In
);
    import epv_pkg::*;

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        epv_phase_e  phase;
        epv_op_e     op;
        logic [15:0] cnt;
        logic [4:0]  pulses;
        logic [12:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic        done;
        logic        refused;
        logic        inMode;
        logic        encWritten;
        logic        sec1;
        logic        sec2;
        logic [4:0]  oscDiv;
        logic [31:0] prdata;
        logic        pslverr;
        epv_pins_s   pin;
    } epv_state_s;

    epv_state_s state_r;
    epv_state_s state_nxt;
    logic       setupRd;
    logic       accessWr;
    logic       busy;
    epv_op_e    reqOp;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // mode pin pattern {p2.7, p2.6, p3.7, p3.6} for an operation
    function automatic logic [3:0] modeBits(input epv_op_e op);
        case (op)
            OP_SIG:      modeBits = 4'h0;
            OP_VERIFY:   modeBits = 4'h3;
            OP_PGM_CODE: modeBits = 4'hB;
            OP_PGM_ENC:  modeBits = 4'hA;
            OP_PGM_SEC1: modeBits = 4'hF;
            OP_PGM_SEC2: modeBits = 4'hC;
            default:     modeBits = 4'h3;
        endcase
    endfunction

    // load value of the down counter from a cycle count
    function automatic logic [15:0] cyc(input int n);
        cyc = 16'(n - 1);
    endfunction

    // --------------------------------------------------------------
    // bus decode
    // --------------------------------------------------------------
    assign setupRd  = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
    assign accessWr = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign busy     = (state_r.phase != PH_IDLE);
    assign reqOp    = epv_op_e'(apbReq.pwdata[`EPV_CTRL_OP_LSB +: 3]);

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        // free-running 5 MHz device oscillator
        if (state_r.oscDiv == `EPV_OSC_HALF) begin
            state_nxt.oscDiv     = 5'h00;
            state_nxt.pin.oscOut = ~state_r.pin.oscOut;
        end else begin
            state_nxt.oscDiv = state_r.oscDiv + 5'h01;
        end
        if (state_r.cnt != 16'h0000) begin
            state_nxt.cnt = state_r.cnt - 16'h0001;
        end
        // read data is registered in the setup cycle
        state_nxt.pslverr = 1'b0;
        if (setupRd) begin
            case (apbReq.paddr)
                `EPV_REG_CTRL:   state_nxt.prdata = {28'h0000000, state_r.op, 1'b0};
                `EPV_REG_ADDR:   state_nxt.prdata = {19'h00000, state_r.addr};
                `EPV_REG_WDATA:  state_nxt.prdata = {24'h000000, state_r.wdata};
                `EPV_REG_STATUS: state_nxt.prdata = {25'h0000000, state_r.sec2, state_r.sec1,
                                                     state_r.encWritten, state_r.inMode,
                                                     state_r.refused, state_r.done, busy};
                `EPV_REG_RDATA:  state_nxt.prdata = {24'h000000, state_r.rdata};
                default: begin
                    state_nxt.prdata  = 32'h00000000;
                    state_nxt.pslverr = 1'b1;
                end
            endcase
        end else if (apbReq.psel & ~apbReq.penable) begin
            state_nxt.pslverr = !(apbReq.paddr inside {`EPV_REG_CTRL, `EPV_REG_ADDR, `EPV_REG_WDATA});
        end
        // writes take effect at the access edge
        if (accessWr && !busy) begin
            case (apbReq.paddr)
                `EPV_REG_ADDR:  state_nxt.addr  = apbReq.pwdata[12:0];
                `EPV_REG_WDATA: state_nxt.wdata = apbReq.pwdata[7:0];
                `EPV_REG_CTRL: begin
                    if (apbReq.pwdata[`EPV_CTRL_GO]) begin
                        state_nxt.op      = reqOp;
                        state_nxt.done    = 1'b0;
                        state_nxt.refused = 1'b0;
                        state_nxt.pulses  = 5'h00;
                        state_nxt.phase   = PH_SETUP;
                        state_nxt.cnt     = cyc(SETUP_CYC);
                        case (reqOp)
                            OP_ENTER: begin
                                // strobe high with reset held first
                                state_nxt.phase                   = PH_ENTRY;
                                state_nxt.cnt                     = cyc(ENTRY_CYC);
                                state_nxt.pin.devResetAct         = 1'b1;
                                state_nxt.pin.programStoreStrobeN = 1'b1;
                                state_nxt.pin.externalAccessHigh  = 1'b1;
                                state_nxt.pin.latchOrProgramPulse = 1'b1;
                            end
                            OP_EXIT: begin
                                state_nxt.phase                   = PH_IDLE;
                                state_nxt.done                    = 1'b1;
                                state_nxt.inMode                  = 1'b0;
                                state_nxt.pin.devResetAct         = 1'b0;
                                state_nxt.pin.programStoreStrobeN = 1'b1;
                                state_nxt.pin.port0OeN            = 1'b1;
                            end
                            OP_PGM_CODE, OP_PGM_ENC: begin
                                // code and table locked once any security bit is set
                                if (!state_r.inMode || state_r.sec1 || state_r.sec2 ||
                                    (reqOp == OP_PGM_ENC && state_r.addr > `EPV_ENC_LAST)) begin
                                    state_nxt.phase   = PH_IDLE;
                                    state_nxt.done    = 1'b1;
                                    state_nxt.refused = 1'b1;
                                end
                            end
                            OP_VERIFY, OP_SIG: begin
                                if (!state_r.inMode || (reqOp == OP_VERIFY && state_r.sec2)) begin
                                    state_nxt.phase   = PH_IDLE;
                                    state_nxt.done    = 1'b1;
                                    state_nxt.refused = 1'b1;
                                end
                            end
                            default: begin
                                // security bits stay programmable after the other one
                                if (!state_r.inMode) begin
                                    state_nxt.phase   = PH_IDLE;
                                    state_nxt.done    = 1'b1;
                                    state_nxt.refused = 1'b1;
                                end
                            end
                        endcase
                        // drive address and mode pins for the operation; data and supply only when programming
                        if (state_nxt.phase == PH_SETUP) begin
                            state_nxt.pin.addr = state_r.addr;
                            {state_nxt.pin.port2Bit7ModeSel, state_nxt.pin.port2Bit6ModeSel,
                             state_nxt.pin.port3Bit7ModeSel, state_nxt.pin.port3Bit6ModeSel} = modeBits(reqOp);
                            if (reqOp == OP_VERIFY || reqOp == OP_SIG) begin
                                state_nxt.pin.port0OeN = 1'b1;
                            end else begin
                                state_nxt.pin.port0Out     = state_r.wdata;
                                state_nxt.pin.port0OeN     = 1'b0;
                                state_nxt.pin.progSupplyOn = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // operation sequencer
        case (state_r.phase)
            PH_ENTRY: begin
                if (state_r.cnt == 16'h0000) begin
                    state_nxt.pin.programStoreStrobeN = 1'b0;
                    state_nxt.inMode                  = 1'b1;
                    state_nxt.done                    = 1'b1;
                    state_nxt.phase                   = PH_IDLE;
                end
            end
            PH_SETUP: begin
                // reads skip the pulse train and sample port 0 next
                if (state_r.cnt == 16'h0000) begin
                    if (state_r.op == OP_VERIFY || state_r.op == OP_SIG) begin
                        state_nxt.phase = PH_READ;
                    end else begin
                        state_nxt.phase                   = PH_LOW;
                        state_nxt.cnt                     = cyc(PULSE_LO_CYC);
                        state_nxt.pin.latchOrProgramPulse = 1'b0;
                    end
                end
            end
            PH_LOW: begin
                // end of a low pulse: raise the pin and count the pulse
                if (state_r.cnt == 16'h0000) begin
                    state_nxt.phase                   = PH_HIGH;
                    state_nxt.cnt                     = cyc(PULSE_HI_CYC);
                    state_nxt.pin.latchOrProgramPulse = 1'b1;
                    state_nxt.pulses                  = state_r.pulses + 5'h01;
                end
            end
            PH_HIGH: begin
                if (state_r.cnt == 16'h0000) begin
                    if (state_r.pulses == `EPV_PULSE_COUNT) begin
                        state_nxt.phase = PH_HOLD;
                        state_nxt.cnt   = cyc(SETUP_CYC);
                    end else begin
                        state_nxt.phase                   = PH_LOW;
                        state_nxt.cnt                     = cyc(PULSE_LO_CYC);
                        state_nxt.pin.latchOrProgramPulse = 1'b0;
                    end
                end
            end
            PH_HOLD: begin
                // supply off first, address and data held for the hold time
                state_nxt.pin.progSupplyOn = 1'b0;
                if (state_r.cnt == 16'h0000) begin
                    state_nxt.phase        = PH_IDLE;
                    state_nxt.done         = 1'b1;
                    state_nxt.pin.port0OeN = 1'b1;
                    if (state_r.op == OP_PGM_SEC1) begin
                        state_nxt.sec1 = 1'b1;
                    end
                    if (state_r.op == OP_PGM_SEC2) begin
                        state_nxt.sec2 = 1'b1;
                    end
                    if (state_r.op == OP_PGM_ENC) begin
                        state_nxt.encWritten = 1'b1;
                    end
                end
            end
            PH_READ: begin
                // port 0 as seen through the pull-ups; encrypted after the table
                state_nxt.rdata = port0In;
                state_nxt.done  = 1'b1;
                state_nxt.phase = PH_IDLE;
            end
            default: begin
            end
        endcase
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r                         <= '0;
            state_r.phase                   <= PH_IDLE;
            state_r.op                      <= OP_ENTER;
            state_r.pin.programStoreStrobeN <= 1'b1;
            state_r.pin.latchOrProgramPulse <= 1'b1;
            state_r.pin.port0OeN            <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign pins           = state_r.pin;
    assign apbRsp.pready  = 1'b1;
    assign apbRsp.prdata  = state_r.prdata;
    assign apbRsp.pslverr = state_r.pslverr & apbReq.psel & apbReq.penable;
endmodule

// ===== test/epv_programmer_assertions.sv
// Purpose: pin-level checks on the program/verify controller
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound from the testbench, counts follow the bound parameters
`timescale 1ns/100ps
module epv_programmer_assertions
    import epv_pkg::*;
#(
    parameter int PULSE_LO_CYC = 25000,
    parameter int PULSE_HI_CYC = 2500
) (
    input wire logic                  mclk,
    input wire logic                  rstn,
    input wire epv_pkg::epv_apb_req_s apbReq,
    input wire epv_pkg::epv_apb_rsp_s apbRsp,
    input wire epv_pkg::epv_pins_s    pins,
    input wire logic [7:0]            port0In
);
    logic [31:0] loCnt_r, hiCnt_r, oscCnt_r;
    logic [5:0]  pulseCnt_r;
    logic        pulsePrev_r, oscPrev_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // pulse widths, pulses per supply window, cycles since the last oscillator edge
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            loCnt_r     <= 32'h0;
            hiCnt_r     <= 32'h0;
            oscCnt_r    <= 32'h0;
            pulseCnt_r  <= 6'h00;
            pulsePrev_r <= 1'b1;
            oscPrev_r   <= 1'b0;
        end else begin
            loCnt_r     <= pins.latchOrProgramPulse ? 32'h0 : loCnt_r + 32'h1;
            hiCnt_r     <= pins.latchOrProgramPulse ? hiCnt_r + 32'h1 : 32'h0;
            oscCnt_r    <= (pins.oscOut != oscPrev_r) ? 32'h0 : oscCnt_r + 32'h1;
            pulseCnt_r  <= pins.progSupplyOn ? pulseCnt_r + {5'h00, pulsePrev_r & ~pins.latchOrProgramPulse} : 6'h00;
            pulsePrev_r <= pins.latchOrProgramPulse;
            oscPrev_r   <= pins.oscOut;
        end
    end

    a_pulse_low_width: assert property ($rose(pins.latchOrProgramPulse) |-> loCnt_r == PULSE_LO_CYC)
        else $error("programming pulse low time is wrong");
    a_pulse_high_gap: assert property ($fell(pins.latchOrProgramPulse) |-> hiCnt_r >= PULSE_HI_CYC)
        else $error("programming pulse high gap too short");
    a_pulse_count: assert property ($fell(pins.progSupplyOn) |-> pulseCnt_r == 6'h19)
        else $error("supply window did not hold 25 pulses");
    a_pulse_with_supply: assert property (!pins.latchOrProgramPulse |-> pins.progSupplyOn)
        else $error("pulse without programming supply");
    a_supply_mode: assert property (pins.progSupplyOn |-> pins.port2Bit7ModeSel
        && (pins.port2Bit6ModeSel ? pins.port3Bit7ModeSel == pins.port3Bit6ModeSel : pins.port3Bit7ModeSel))
        else $error("programming supply with a non-programming mode");
    a_port0_release: assert property (!pins.port0OeN |-> pins.port2Bit7ModeSel)
        else $error("port 0 driven in a read mode");
    a_pins_hold: assert property (pins.progSupplyOn && $past(pins.progSupplyOn) |->
        $stable(pins.addr) && $stable(pins.port0Out)) else $error("address or data moved while programming");
    a_table_range: assert property (pins.progSupplyOn && !pins.port2Bit6ModeSel && !pins.port3Bit6ModeSel |->
        pins.addr <= 13'h001F) else $error("table address above its range");
    a_entry_order: assert property ($fell(pins.programStoreStrobeN) |-> pins.devResetAct && $past(pins.devResetAct, 3))
        else $error("strobe fell without reset held");
    a_osc_running: assert property (pins.devResetAct && !pins.programStoreStrobeN |-> oscCnt_r <= 32'h18)
        else $error("device oscillator too slow in mode");

    c_program: cover property ($fell(pins.progSupplyOn));
    c_sig_read: cover property (pins.devResetAct && !pins.programStoreStrobeN && !pins.port3Bit7ModeSel);
    c_bus_error: cover property (apbRsp.pslverr && apbReq.penable);
endmodule

// ===== test/epv_device_model.sv
// Purpose: behavioural device in program/verify mode
// Assumes: pins change just after mclk edges
// Notes:   port 0 floats high through pull-ups when nobody drives it
`timescale 1ns/100ps
module epv_device_model
    import epv_pkg::*;
#(
    parameter logic [7:0] SIG_MAKER = 8'h3C,  // arbitrary value
    parameter logic [7:0] SIG_PART  = 8'h6E   // arbitrary value
) (
    input  wire logic               mclk,
    input  wire epv_pkg::epv_pins_s pins,
    output logic [7:0]              port0In
);
    logic [7:0] mem [8192];
    logic [7:0] encTab [32];
    logic [3:0] mode;
    logic       encDone, sec1, sec2, pulsePrev, inMode, sigRd, codeRd;
    int         pulses;

    // mode decode from the four select pins
    assign mode   = {pins.port2Bit7ModeSel, pins.port2Bit6ModeSel, pins.port3Bit7ModeSel, pins.port3Bit6ModeSel};
    assign inMode = pins.devResetAct && !pins.programStoreStrobeN;
    assign sigRd  = inMode && !pins.progSupplyOn && mode == 4'h0;
    assign codeRd = inMode && !pins.progSupplyOn && mode == 4'h3 && !sec2;

    // erased array, blank table, both lock bits clear
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        encDone   = 1'b0;
        sec1      = 1'b0;
        sec2      = 1'b0;
        pulsePrev = 1'b1;
        pulses    = 0;
    end

    // commit after the 25th pulse; a lock bit refuses code and table
    always @(posedge mclk) begin
        if (!pins.progSupplyOn) begin
            pulses = 0;
        end else if (!pulsePrev && pins.latchOrProgramPulse) begin
            pulses++;
        end
        if (pulses == 25) begin
            pulses = 0;
            case (mode)
                4'hB: if (!sec1 && !sec2) mem[pins.addr] = pins.port0Out;
                4'hA: if (!sec1 && !sec2) begin
                    encTab[pins.addr[4:0]] = pins.port0Out;
                    encDone = 1'b1;
                end
                4'hF: sec1 = 1'b1;
                4'hC: sec2 = 1'b1;
                default: ;
            endcase
        end
        pulsePrev = pins.latchOrProgramPulse;
    end

    // port 0 level: programmer, device read-out, else pull-ups; the table only enters as the key of encrypted code reads
    always_comb begin
        if (!pins.port0OeN) port0In = pins.port0Out;
        else if (sigRd && pins.addr == 13'h0030) port0In = SIG_MAKER;
        else if (sigRd && pins.addr == 13'h0031) port0In = SIG_PART;
        else if (codeRd && encDone) port0In = ~(mem[pins.addr] ^ encTab[pins.addr[4:0]]);
        else if (codeRd) port0In = mem[pins.addr];
        else port0In = 8'hFF;
    end
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench for the program/verify controller
// Assumes: shortened counts, behavioural device model
// Notes:   software view over APB, plus direct checks of the entry and reset pins
`timescale 1ns/100ps
`include "epv_cfg.svh"
module testbench;
    import epv_pkg::*;
    logic         mclk;
    logic         rstn;
    epv_apb_req_s apbReq;
    epv_apb_rsp_s apbRsp;
    epv_pins_s    pins;
    logic [7:0]   port0In;
    logic [31:0]  rd;
    logic [7:0]   b;
    logic [7:0]   encTab [32];
    logic         err;
    int           fails;
    int           nCompared;

    epv_programmer #(.PULSE_LO_CYC(20), .PULSE_HI_CYC(5), .SETUP_CYC(4), .ENTRY_CYC(4)) dut (
        .mclk(mclk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp), .pins(pins), .port0In(port0In));
    epv_device_model u_dev (.mclk(mclk), .pins(pins), .port0In(port0In));

    // 250 MHz clock
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one APB transfer; read data and error taken at the pready edge
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        apbReq <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        do @(posedge mclk); while (apbRsp.pready !== 1'b1);
        rd  = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
        @(posedge mclk);
    endtask

    // order one operation, poll until done, check refusal, fetch read byte
    task automatic run_op(input epv_op_e code, input logic [12:0] addr, input logic [7:0] wdata, input logic refused);
        int n;
        xfer(1'b1, `EPV_REG_ADDR, {19'h0, addr});
        xfer(1'b1, `EPV_REG_WDATA, {24'h0, wdata});
        xfer(1'b1, `EPV_REG_CTRL, {28'h0, code, 1'b1});
        n = 0;
        do begin
            xfer(1'b0, `EPV_REG_STATUS, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 2000);
        check({30'h0, rd[2:1]}, {30'h0, refused, 1'b1});
        xfer(1'b0, `EPV_REG_RDATA, 32'h0);
        b = rd[7:0];
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        repeat (80000) @(posedge mclk);
        fails++;
        print_verdict();
    end

    initial begin
        fails = 0;
        nCompared = 0;
        apbReq = '0;
        rstn = 1'b0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        xfer(1'b0, `EPV_REG_STATUS, 32'h0);
        check({25'h0, rd[6:0]}, 32'h0);
        xfer(1'b1, 12'h014, 32'h0);
        check({31'h0, err}, 32'h1);
        xfer(1'b1, `EPV_REG_RDATA, 32'h0);
        check({31'h0, err}, 32'h1);
        xfer(1'b0, 12'h014, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        run_op(OP_VERIFY, 13'h0000, 8'h00, 1'b1);
        $display("test reset and bus done");
        run_op(OP_ENTER, 13'h0000, 8'h00, 1'b0);
        check({29'h0, pins.devResetAct, pins.programStoreStrobeN, pins.externalAccessHigh}, 32'h5);
        run_op(OP_VERIFY, 13'h0123, 8'h00, 1'b0);
        check({24'h0, b}, 32'hFF);
        run_op(OP_SIG, 13'h0030, 8'h00, 1'b0);
        check({24'h0, b}, {24'h0, u_dev.SIG_MAKER});
        run_op(OP_SIG, 13'h0031, 8'h00, 1'b0);
        check({24'h0, b}, {24'h0, u_dev.SIG_PART});
        run_op(OP_PGM_CODE, 13'h0123, 8'h5A, 1'b0);
        run_op(OP_PGM_CODE, 13'h1FFF, 8'hC3, 1'b0);
        run_op(OP_VERIFY, 13'h0123, 8'h00, 1'b0);
        check({24'h0, b}, 32'h5A);
        run_op(OP_VERIFY, 13'h1FFF, 8'h00, 1'b0);
        check({24'h0, b}, 32'hC3);
        $display("test entry and code done");
        for (int i = 0; i < 32; i++) begin
            encTab[i] = 8'hA5 ^ 8'(i);
            run_op(OP_PGM_ENC, 13'(i), encTab[i], 1'b0);
        end
        run_op(OP_PGM_ENC, 13'h0020, 8'h00, 1'b1);
        run_op(OP_VERIFY, 13'h0123, 8'h00, 1'b0);
        check({24'h0, b}, {24'h0, ~(8'h5A ^ encTab[3])});
        $display("test table done");
        xfer(1'b1, `EPV_REG_CTRL, {28'h0, OP_PGM_SEC1, 1'b1});
        xfer(1'b1, `EPV_REG_ADDR, 32'h0155);
        xfer(1'b0, `EPV_REG_ADDR, 32'h0);
        check(rd, 32'h0123);
        xfer(1'b0, `EPV_REG_CTRL, 32'h0);
        check(rd, {28'h0, OP_PGM_SEC1, 1'b0});
        run_op(OP_PGM_SEC1, 13'h0000, 8'h00, 1'b0);
        run_op(OP_PGM_CODE, 13'h0010, 8'h00, 1'b1);
        run_op(OP_PGM_ENC, 13'h0001, 8'h00, 1'b1);
        run_op(OP_VERIFY, 13'h0010, 8'h00, 1'b0);
        check({24'h0, b}, {24'h0, encTab[16]});
        run_op(OP_PGM_SEC2, 13'h0000, 8'h00, 1'b0);
        run_op(OP_VERIFY, 13'h0123, 8'h00, 1'b1);
        xfer(1'b0, `EPV_REG_STATUS, 32'h0);
        check({25'h0, rd[6:0]}, 32'h7E);
        run_op(OP_EXIT, 13'h0000, 8'h00, 1'b0);
        check({29'h0, pins.devResetAct, pins.programStoreStrobeN, pins.externalAccessHigh}, 32'h3);
        run_op(OP_SIG, 13'h0030, 8'h00, 1'b1);
        $display("test locks and exit done");
        print_verdict();
    end
endmodule

bind epv_programmer epv_programmer_assertions #(.PULSE_LO_CYC(PULSE_LO_CYC), .PULSE_HI_CYC(PULSE_HI_CYC)) u_chk (
    .mclk(mclk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp), .pins(pins), .port0In(port0In));
